// ---- tb/dcs_ctrl_properties.sv ----
`timescale 1ns/100ps
// state and handshake checks on the control block ports
module dcs_ctrl_chk
    import dcs_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic obj_wr,
    input wire logic obj_rd,
    input wire logic [15:0] obj_idx,
    input wire logic [15:0] obj_rdata,
    input wire logic obj_ack,
    input wire dcs_pkg::dcs_nmt_t nmt_state,
    input wire logic init_done,
    input wire logic fault_nonfatal,
    input wire logic [2:0] qstop_option,
    input wire logic brake_on,
    input wire logic power_on,
    input wire logic drive_enable,
    input wire logic param_wr_ok,
    input wire logic [DCS_STATE_W-1:0] state_onehot
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // block is live only when enabled and operational
    wire on = ce && (nmt_state == DCS_NMT_OPER);
    property p_ack; on && (obj_wr || obj_rd) |=> obj_ack; endproperty
    a_ack: assert property (p_ack) else $error("access not acked");
    // a frozen clock enable may hold an earlier acknowledge
    property p_off; !on |=> !(obj_ack && $past(ce)) && $stable(state_onehot); endproperty
    a_off: assert property (p_off) else $error("block moved while idle");
    property p_rd; on && obj_rd && obj_idx == DCS_IDX_STAT |=>
        obj_rdata[7:0] == $past(state_onehot); endproperty
    a_rd: assert property (p_rd) else $error("status read wrong");
    property p_init; on && init_done && state_onehot == DCS_S_NOT_READY |=>
        state_onehot == DCS_S_SW_DIS; endproperty
    a_init: assert property (p_init) else $error("init exit wrong");
    property p_brake; brake_on == (state_onehot == DCS_S_NOT_READY); endproperty
    a_brake: assert property (p_brake) else $error("brake wrong");
    property p_par; param_wr_ok == (state_onehot != DCS_S_NOT_READY); endproperty
    a_par: assert property (p_par) else $error("param gate wrong");
    property p_sw; state_onehot == DCS_S_SW_ON |-> power_on && !drive_enable; endproperty
    a_sw: assert property (p_sw) else $error("switched on outputs");
    property p_run; state_onehot inside {DCS_S_OP_EN, DCS_S_QSTOP, DCS_S_FLT_REACT}
        |-> power_on && drive_enable; endproperty
    a_run: assert property (p_run) else $error("drive not powered");
    property p_flt; state_onehot inside {DCS_S_FAULT, DCS_S_SW_DIS} |->
        !drive_enable && !power_on; endproperty
    a_flt: assert property (p_flt) else $error("drive on while off");
    property p_qs; state_onehot == DCS_S_QSTOP && qstop_option == DCS_QS_STAY |=>
        state_onehot inside {DCS_S_QSTOP, DCS_S_OP_EN, DCS_S_FLT_REACT}; endproperty
    a_qs: assert property (p_qs) else $error("left quick stop");
    property p_fr; on && fault_nonfatal && state_onehot == DCS_S_OP_EN |=>
        state_onehot == DCS_S_FLT_REACT; endproperty
    a_fr: assert property (p_fr) else $error("fault not reacted");
    c_op: cover property (state_onehot == DCS_S_OP_EN);
    c_qs: cover property (state_onehot == DCS_S_QSTOP);
    c_fl: cover property (state_onehot == DCS_S_FAULT);
endmodule : dcs_ctrl_chk
bind dcs_ctrl dcs_ctrl_chk u_chk (.clk, .rst_n, .ce, .obj_wr, .obj_rd, .obj_idx,
    .obj_rdata, .obj_ack, .nmt_state, .init_done, .fault_nonfatal, .qstop_option,
    .brake_on, .power_on, .drive_enable, .param_wr_ok, .state_onehot);

// ---- tb/dcs_host.sv ----
`timescale 1ns/100ps
// host side: one object access per call, strobe held for one sampling edge
module dcs_host (
    // clocking
    input wire logic clk,
    // object access port
    output logic obj_wr,
    output logic obj_rd,
    output logic [15:0] obj_idx,
    output logic [15:0] obj_wdata,
    input wire logic obj_ack,
    input wire logic [15:0] obj_rdata
);
    initial begin
        obj_wr = 0;
        obj_rd = 0;
        obj_idx = 16'h0000;
        obj_wdata = 16'h0000;
    end
    // write or read one object; released lines show the inverse value
    task automatic acc(input logic w, input logic [15:0] i, input logic [15:0] d,
                       output logic a, output logic [15:0] r);
        @(negedge clk);
        obj_wr = w;
        obj_rd = !w;
        obj_idx = i;
        obj_wdata = d;
        @(negedge clk);
        a = obj_ack;
        r = obj_rdata;
        obj_wr = 0;
        obj_rd = 0;
        obj_idx = ~i;
        obj_wdata = ~d;
    endtask : acc
endmodule : dcs_host

// ---- tb/drive_control_state_machine_tb_top.sv ----
`timescale 1ns/100ps
module drive_control_state_machine_tb_top;
    import dcs_pkg::*;
    logic clk = 0, rst_n = 0, ce = 1, init_done = 0, f_nf = 0, f_f = 0, frd = 0, qsd = 0;
    logic [2:0] qopt = 3'h0;
    dcs_nmt_t nmt = DCS_NMT_OPER;
    logic wr, rd, ack, brake_on, power_on, drive_enable, qrun, pok, mon, mode_valid, a;
    logic [15:0] idx, wd, rdata, r;
    logic [4:0] mode_active;
    logic [7:0] state_onehot;
    int mismatches = 0, n_tests = 0, st = 1, m, k;
    int seq[$] = '{3, 1, 6, 1, 2, 1, 2, 3, 4, 3, 1, 2, 3, 5, 1, 2, 3, 6};
    int tbl[5] = '{6, 1, 3, 4, 7};
    always #2.5 clk = ~clk;
    dcs_host u_host (.clk(clk), .obj_wr(wr), .obj_rd(rd), .obj_idx(idx), .obj_wdata(wd),
        .obj_ack(ack), .obj_rdata(rdata));
    dcs_ctrl DUT (.clk(clk), .rst_n(rst_n), .ce(ce), .obj_wr(wr), .obj_rd(rd),
        .obj_idx(idx), .obj_wdata(wd), .obj_rdata(rdata), .obj_ack(ack), .nmt_state(nmt),
        .init_done(init_done), .fault_nonfatal(f_nf), .fault_fatal(f_f),
        .fault_react_done(frd), .qstop_done(qsd), .qstop_option(qopt),
        .brake_on(brake_on), .power_on(power_on), .drive_enable(drive_enable),
        .qstop_run(qrun), .param_wr_ok(pok), .monitor_on(mon), .mode_active(mode_active),
        .mode_valid(mode_valid), .state_onehot(state_onehot));
    // reference state model
    function automatic int nxt(int s, int c, int o);
        case (s)
            2: return (c == 1) ? 4 : 2;
            4: return (c == 2) ? 8 : (c == 5 || c == 6) ? 2 : 4;
            8: return (c == 3) ? 16 : (c == 1) ? 4 : (c == 5 || c == 6) ? 2 : 8;
            16: return (c == 4) ? 8 : (c == 1) ? 4 : (c == 5) ? 2 : (c == 6) ? 32 : 16;
            32: return (c == 3 && o == 5) ? 16 : (c == 5 && o != 5) ? 2 : 32;
            128: return (c == 7) ? 2 : 128;
            default: return s;
        endcase
    endfunction : nxt
    task automatic chk(logic [15:0] got, logic [15:0] exp, string msg);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %0t %s", $time, msg);
        end
    endtask : chk
    // drive-side outputs expected from the model state
    task automatic outs;
        chk(16'(power_on), 16'(st inside {8, 16, 32, 64}), "power");
        chk(16'(drive_enable), 16'(st inside {16, 32, 64}), "drive");
        chk(16'(qrun), 16'(st inside {32, 64}), "qstop run");
        chk(16'(brake_on), 16'(st == 1), "brake state");
    endtask : outs
    // one command write, then state and status read compared to the model
    task automatic cmd(int c);
        u_host.acc(1, DCS_IDX_CMD, 16'(c), a, r);
        chk(16'(a), 1, "cmd ack");
        // a fault still present keeps the fault state
        st = (f_nf || f_f) ? st : nxt(st, c, qopt);
        @(negedge clk);
        chk(16'(state_onehot), 16'(st), "state");
        outs();
        u_host.acc(0, DCS_IDX_STAT, 0, a, r);
        chk(r[7:0], 16'(st), "status");
    endtask : cmd
    // one event pulse on a drive-side input
    task automatic pulse(ref logic s, input int e);
        s = 1;
        @(negedge clk);
        s = 0;
        st = e;
        chk(16'(state_onehot), 16'(e), "event state");
        outs();
    endtask : pulse
    task automatic results;
        $display("tests %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : results
    initial begin
        repeat (3000) @(posedge clk);
        mismatches++;
        results();
    end
    initial begin
        void'($urandom(32'h2e3d));
        repeat (8) @(negedge clk);
        rst_n = 1;
        chk(16'(brake_on), 1, "brake");
        chk(16'(pok), 0, "param");
        u_host.acc(1, DCS_IDX_MODE, 16'(DCS_M_HOMING), a, r);
        chk(16'(a), 1, "init mode ack");
        @(negedge clk);
        chk(16'(mode_valid), 0, "init mode refused");
        chk(16'(state_onehot), 16'(st), "init hold");
        pulse(init_done, 2);
        chk(16'(mon), 1, "monitor");
        nmt = DCS_NMT_PREOP;
        u_host.acc(1, DCS_IDX_CMD, 16'h0001, a, r);
        chk(16'(a), 0, "preop ack");
        nmt = DCS_NMT_STOP;
        u_host.acc(1, DCS_IDX_CMD, 16'h0001, a, r);
        chk(16'(a), 0, "stop ack");
        nmt = DCS_NMT_OPER;
        ce = 0;
        u_host.acc(1, DCS_IDX_CMD, 16'h0001, a, r);
        chk(16'(a), 0, "ce ack");
        ce = 1;
        @(negedge clk);
        chk(16'(state_onehot), 16'(st), "idle hold");
        foreach (seq[i]) cmd(seq[i]);
        pulse(qsd, 2);
        qopt = DCS_QS_STAY;
        foreach (seq[i]) if (i > 13) cmd(seq[i]);
        pulse(qsd, 32);
        cmd(5);
        cmd(3);
        pulse(f_nf, 64);
        pulse(frd, 128);
        chk(16'(drive_enable), 0, "fault drive");
        cmd(7);
        pulse(f_f, 64);
        f_f = 1;
        pulse(frd, 128);
        cmd(7);
        f_f = 0;
        cmd(7);
        for (int i = 0; i < 8; i++) begin
            m = (i < 5) ? tbl[i] : int'($urandom % 256);
            k = -1;
            foreach (tbl[j]) if (tbl[j] == m) k = j;
            u_host.acc(1, DCS_IDX_MODE, 16'(m), a, r);
            @(negedge clk);
            chk(16'(mode_active), (k < 0) ? 0 : 16'(1 << k), "mode");
            chk(16'(mode_valid), 16'(k >= 0), "mode valid");
        end
        u_host.acc(0, 16'h6050, 0, a, r);
        chk(r, 0, "unmapped");
        // second reset in mid-run returns to initializing
        rst_n = 0;
        @(negedge clk);
        rst_n = 1;
        st = 1;
        chk(16'(state_onehot), 16'(st), "reset state");
        chk(16'(mode_valid), 0, "reset mode");
        outs();
        results();
    end
endmodule : drive_control_state_machine_tb_top

// ---- verilog/dcs_ctrl.sv ----
`timescale 1ns/100ps
// How it works
// - host writes command word; device acts on it
// - state report word always shows state
// - active mode taken from mode selector
// - five modes: homing, position, velocity, torque, interpolated
// - block runs only in operational comm state
// - only commands valid for state transition
// - initializing: brake on, drive disabled
// - switch-on-disabled: params writable, drive disabled
// - params writable except while initializing
// - switched on: power ready, drive disabled
// - operation enabled: no fault, drive powered
// - quick stop active: stopping, drive powered
// - option 5 holds quick stop until enable
// - non-fatal fault: fault reaction, stop, powered
// - fault state keeps drive disabled
// - reset initializes, then switch-on-disabled, monitoring on
// - shutdown, switch-on, enable-op step forward
// - disable-voltage: switch-on-disabled, power off now, except in quick stop under option 5
// - quick stop; completes to switch-on-disabled unless 5
module dcs_ctrl
    import dcs_pkg::*;
(
    // clocking
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // object access port
    input wire logic obj_wr,
    input wire logic obj_rd,
    input wire logic [15:0] obj_idx,
    input wire logic [15:0] obj_wdata,
    output logic [15:0] obj_rdata,
    output logic obj_ack,
    // communication layer state
    input wire dcs_pkg::dcs_nmt_t nmt_state,
    // drive-side events
    input wire logic init_done,
    input wire logic fault_nonfatal,
    input wire logic fault_fatal,
    input wire logic fault_react_done,
    input wire logic qstop_done,
    input wire logic [2:0] qstop_option,
    // drive-side controls
    output logic brake_on,
    output logic power_on,
    output logic drive_enable,
    output logic qstop_run,
    output logic param_wr_ok,
    output logic monitor_on,
    output logic [DCS_NMODES-1:0] mode_active,
    output logic mode_valid,
    output logic [DCS_STATE_W-1:0] state_onehot
);
    import dcs_pkg::*;

    // state register and next value
    dcs_state_t state_reg;
    dcs_state_t state_next;
    // command word, mode selector storage
    logic [15:0] cmd_q;
    logic [7:0] mode_q;
    // pending command pulse from a fresh write
    logic cmd_new_reg;
    logic cmd_new_next;
    // registered outputs
    logic [15:0] rdata_reg;
    logic ack_reg;
    logic [DCS_NMODES-1:0] mode_active_reg;
    logic mode_valid_reg;

    // whole block runs only when comm layer operational
    wire run = ce && (nmt_state == DCS_NMT_OPER);

    // address decode
    wire hit_cmd = (obj_idx == DCS_IDX_CMD);
    wire hit_stat = (obj_idx == DCS_IDX_STAT);
    wire hit_mode = (obj_idx == DCS_IDX_MODE);
    wire wr_cmd = run && obj_wr && hit_cmd;
    wire wr_mode = run && obj_wr && hit_mode && param_wr_ok;
    wire [3:0] cmd = cmd_q[DCS_CMD_MSB:DCS_CMD_LSB];
    wire cmd_go = cmd_new_reg;
    wire qs_stay = (qstop_option == DCS_QS_STAY);

    // command word storage
    dcs_reg #(.W(16), .RST(DCS_CMD_RST)) u_cmd (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .we(wr_cmd),
        .wdata(obj_wdata),
        .q(cmd_q)
    );

    // mode selector storage
    dcs_reg #(.W(8), .RST(DCS_MODE_RST)) u_mode (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .we(wr_mode),
        .wdata(obj_wdata[7:0]),
        .q(mode_q)
    );

    // a command acts once, in the cycle after its write
    assign cmd_new_next = wr_cmd;

    // state transitions
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            // self test finishes to switch-on-disabled
            DCS_S_NOT_READY: begin
                if (init_done) begin
                    state_next = DCS_S_SW_DIS;
                end
            end
            // wait for shutdown
            DCS_S_SW_DIS: begin
                if (cmd_go && cmd == DCS_C_SHUTDOWN) begin
                    state_next = DCS_S_READY;
                end
            end
            // ready: switch on or drop back
            DCS_S_READY: begin
                if (cmd_go && cmd == DCS_C_SWITCH_ON) begin
                    state_next = DCS_S_SW_ON;
                end else if (cmd_go && (cmd == DCS_C_QUICK_STOP ||
                                        cmd == DCS_C_DISABLE_V)) begin
                    state_next = DCS_S_SW_DIS;
                end
            end
            // switched on
            DCS_S_SW_ON: begin
                if (cmd_go && cmd == DCS_C_ENABLE_OP) begin
                    state_next = DCS_S_OP_EN;
                end else if (cmd_go && cmd == DCS_C_SHUTDOWN) begin
                    state_next = DCS_S_READY;
                end else if (cmd_go && (cmd == DCS_C_DISABLE_V ||
                                        cmd == DCS_C_QUICK_STOP)) begin
                    state_next = DCS_S_SW_DIS;
                end
            end
            // normal operation
            DCS_S_OP_EN: begin
                if (cmd_go && cmd == DCS_C_DISABLE_OP) begin
                    state_next = DCS_S_SW_ON;
                end else if (cmd_go && cmd == DCS_C_SHUTDOWN) begin
                    state_next = DCS_S_READY;
                end else if (cmd_go && cmd == DCS_C_DISABLE_V) begin
                    state_next = DCS_S_SW_DIS;
                end else if (cmd_go && cmd == DCS_C_QUICK_STOP) begin
                    state_next = DCS_S_QSTOP;
                end
            end
            // quick stop running
            DCS_S_QSTOP: begin
                if (qs_stay) begin
                    if (cmd_go && cmd == DCS_C_ENABLE_OP) begin
                        state_next = DCS_S_OP_EN;
                    end
                end else if (qstop_done || (cmd_go && cmd == DCS_C_DISABLE_V)) begin
                    state_next = DCS_S_SW_DIS;
                end
            end
            // fault reaction runs to fault
            DCS_S_FLT_REACT: begin
                if (fault_react_done) begin
                    state_next = DCS_S_FAULT;
                end
            end
            // fault: leave on fault reset once cause is gone
            DCS_S_FAULT: begin
                if (cmd_go && cmd == DCS_C_FAULT_RESET && !fault_nonfatal &&
                    !fault_fatal) begin
                    state_next = DCS_S_SW_DIS;
                end
            end
            // illegal code recovers to initializing
            default: begin
                state_next = DCS_S_NOT_READY;
            end
        endcase
        // any fault outside initializing and fault handling takes over
        if ((fault_nonfatal || fault_fatal) && state_reg != DCS_S_NOT_READY &&
            state_reg != DCS_S_FLT_REACT && state_reg != DCS_S_FAULT) begin
            state_next = DCS_S_FLT_REACT;
        end
    end

    // state register; reset enters initializing
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg <= DCS_S_NOT_READY;
            cmd_new_reg <= 1'b0;
        end else if (run) begin
            state_reg <= state_next;
            cmd_new_reg <= cmd_new_next;
        end else if (ce) begin
            cmd_new_reg <= 1'b0;
        end
    end

    // state report word, code per state
    wire [15:0] stat_word = {DCS_ZERO8, state_reg};

    // read data mux
    wire [15:0] rd_mux = hit_cmd ? cmd_q :
                         hit_stat ? stat_word :
                         hit_mode ? {DCS_ZERO8, mode_q} : DCS_ZERO16;

    // mode decode from selector
    wire [DCS_NMODES-1:0] mode_dec = {
        mode_q == DCS_M_INTERP,
        mode_q == DCS_M_PROF_TRQ,
        mode_q == DCS_M_PROF_VEL,
        mode_q == DCS_M_PROF_POS,
        mode_q == DCS_M_HOMING
    };

    // read answer and mode outputs
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata_reg <= DCS_ZERO16;
            ack_reg <= 1'b0;
            mode_active_reg <= '0;
            mode_valid_reg <= 1'b0;
        end else if (ce) begin
            ack_reg <= run && (obj_rd || obj_wr);
            if (run && obj_rd) begin
                rdata_reg <= rd_mux;
            end
            mode_active_reg <= mode_dec;
            mode_valid_reg <= |mode_dec;
        end
    end

    // outputs
    assign obj_rdata = rdata_reg;
    assign obj_ack = ack_reg;
    assign mode_active = mode_active_reg;
    assign mode_valid = mode_valid_reg;
    assign state_onehot = state_reg;

    // drive-side controls from state
    assign brake_on = (state_reg == DCS_S_NOT_READY);
    assign power_on = (state_reg == DCS_S_SW_ON) || (state_reg == DCS_S_OP_EN) ||
                      (state_reg == DCS_S_QSTOP) ||
                      (state_reg == DCS_S_FLT_REACT);
    assign drive_enable = (state_reg == DCS_S_OP_EN) || (state_reg == DCS_S_QSTOP) ||
                          (state_reg == DCS_S_FLT_REACT);
    assign qstop_run = (state_reg == DCS_S_QSTOP) ||
                       (state_reg == DCS_S_FLT_REACT);
    assign param_wr_ok = (state_reg != DCS_S_NOT_READY);
    assign monitor_on = (state_reg != DCS_S_NOT_READY);
endmodule : dcs_ctrl

// ---- verilog/dcs_pkg.sv ----
package dcs_pkg;
    // object indices of the three registers
    localparam logic [15:0] DCS_IDX_CMD = 16'h6040;
    localparam logic [15:0] DCS_IDX_STAT = 16'h6041;
    localparam logic [15:0] DCS_IDX_MODE = 16'h6060;

    // reset values
    localparam logic [15:0] DCS_CMD_RST = 16'h0000;
    localparam logic [7:0] DCS_MODE_RST = 8'h00;
    localparam logic [15:0] DCS_ZERO16 = 16'h0000;
    localparam logic [7:0] DCS_ZERO8 = 8'h00;

    // command codes held in the low nibble of the command word
    localparam int DCS_CMD_LSB = 0;
    localparam int DCS_CMD_MSB = 3;
    localparam logic [3:0] DCS_C_NONE = 4'h0;
    localparam logic [3:0] DCS_C_SHUTDOWN = 4'h1;
    localparam logic [3:0] DCS_C_SWITCH_ON = 4'h2;
    localparam logic [3:0] DCS_C_ENABLE_OP = 4'h3;
    localparam logic [3:0] DCS_C_DISABLE_OP = 4'h4;
    localparam logic [3:0] DCS_C_DISABLE_V = 4'h5;
    localparam logic [3:0] DCS_C_QUICK_STOP = 4'h6;
    localparam logic [3:0] DCS_C_FAULT_RESET = 4'h7;

    // quick stop option code that holds quick-stop-active
    localparam logic [2:0] DCS_QS_STAY = 3'h5;

    // operating modes
    localparam logic [7:0] DCS_M_HOMING = 8'h06;
    localparam logic [7:0] DCS_M_PROF_POS = 8'h01;
    localparam logic [7:0] DCS_M_PROF_VEL = 8'h03;
    localparam logic [7:0] DCS_M_PROF_TRQ = 8'h04;
    localparam logic [7:0] DCS_M_INTERP = 8'h07;

    // communication-layer states
    typedef enum logic [1:0] {
        DCS_NMT_PREOP = 2'h0,
        DCS_NMT_OPER = 2'h1,
        DCS_NMT_STOP = 2'h2
    } dcs_nmt_t;

    // device states, one-hot
    typedef enum logic [7:0] {
        DCS_S_NOT_READY = 8'h01,
        DCS_S_SW_DIS = 8'h02,
        DCS_S_READY = 8'h04,
        DCS_S_SW_ON = 8'h08,
        DCS_S_OP_EN = 8'h10,
        DCS_S_QSTOP = 8'h20,
        DCS_S_FLT_REACT = 8'h40,
        DCS_S_FAULT = 8'h80
    } dcs_state_t;

    // active-mode one-hot encoding (bit per mode)
    localparam int DCS_NMODES = 5;
    localparam int DCS_STATE_W = 8;
endpackage : dcs_pkg

// ---- verilog/dcs_reg.sv ----
`timescale 1ns/100ps
// one writable register with hold under clock enable
module dcs_reg #(
    parameter int W = 16,
    parameter logic [W-1:0] RST = '0
) (
    // clocking
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // write port
    input wire logic we,
    input wire logic [W-1:0] wdata,
    // stored value
    output logic [W-1:0] q
);
    // stored value updates on write
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q <= RST;
        end else if (ce && we) begin
            q <= wdata;
        end
    end
endmodule : dcs_reg
